//--- logic/pbip_cfg.svh
// Register indexes, reset values and field positions of the port block
`ifndef PBIP_CFG_SVH
`define PBIP_CFG_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define PBIP_IDX_P0_LEVEL   16'hFFD0
`define PBIP_IDX_P0_ASEL    16'hFFEF
`define PBIP_IDX_DATA       16'hFFD8
`define PBIP_IDX_DIR        16'hFFE8
`define PBIP_IDX_FUNC       16'hFFF0
`define PBIP_IDX_SCLK       16'hFFF1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PBIP_P0_ASEL_RST    8'h00
`define PBIP_DATA_RST       8'h00
`define PBIP_DIR_RST        8'h00
`define PBIP_FUNC_RST       8'h00
`define PBIP_SCLK_RST       2'h0

// ----------------------------------------------------------------
// Fields and answers
// ----------------------------------------------------------------
`define PBIP_SCLK_A_EXT     0
`define PBIP_SCLK_B_EXT     1
`define PBIP_RESP_OKAY      2'h0
`define PBIP_RESP_SLVERR    2'h2
`define PBIP_ADDR_W         18

`endif

//--- logic/pbip_pkg.sv
// Types shared by the port block modules
package pbip_pkg;

    typedef enum logic {PBIP_WR_IDLE, PBIP_WR_RESP} pbip_wr_e;

    typedef enum logic {PBIP_RD_IDLE, PBIP_RD_DATA} pbip_rd_e;

    // Drive of the eight standard pins, all registered
    typedef struct packed {
        logic [7:0] pmos_on;
        logic [7:0] nmos_on;
        logic [7:0] pullup_on;
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
    } pbip_drv_s;

    // Per-pin peripheral request
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pbip_per_s;

endpackage

//--- logic/pbip_sync.sv
// Two flip-flop synchroniser for pin levels
module pbip_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

//--- logic/pbip_drive.sv
// Output buffer decode of the standard I/O pins
module pbip_drive
    import pbip_pkg::*;
#(
    parameter bit PULLUP_BUILT = 1'b1
) (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // Control
    input  wire logic      [7:0] data,
    input  wire logic      [7:0] dir,
    input  wire logic      [7:0] func,
    input  wire logic      [7:0] in_only,
    input  wire pbip_pkg::pbip_per_s per,
    // Pad drive
    output pbip_pkg::pbip_drv_s  drv
);

    logic [7:0] oe_w;
    logic [7:0] out_w;

    always_comb
    begin
        out_w = (func & per.out) | (~func & data);
        oe_w  = ((func & per.oe) | (~func & dir)) & ~in_only;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drv.pmos_on   <= 8'h00;
            drv.nmos_on   <= 8'h00;
            drv.pin_o     <= 8'h00;
            drv.pin_oe    <= 8'h00;
            drv.pullup_on <= PULLUP_BUILT ? 8'hFF : 8'h00;
        end
        else
        begin
            drv.pmos_on   <= oe_w & out_w;
            drv.nmos_on   <= oe_w & ~out_w;
            drv.pin_o     <= out_w;
            drv.pin_oe    <= oe_w;
            // Pull-up is not a function of direction or data
            drv.pullup_on <= PULLUP_BUILT ? 8'hFF : 8'h00;
        end
    end

endmodule

//--- logic/pbip_top.sv
// Port 0 input port and standard I/O port with AXI4-Lite registers
`include "pbip_cfg.svh"

module pbip_top
    import pbip_pkg::*;
#(
    parameter bit PULLUP_BUILT = 1'b1,
    parameter int SCLK_A_BIT   = 1,
    parameter int SCLK_B_BIT   = 4
) (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic [`PBIP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`PBIP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Port 0 pins and converter routing
    input  wire logic [7:0]              p0_pin_i,
    output logic      [7:0]              p0_adc_route,
    output logic      [7:0]              p0_gen_in,
    // Standard I/O pins
    input  wire logic [7:0]              std_pin_i,
    output logic      [7:0]              std_pin_o,
    output logic      [7:0]              std_pin_oe,
    output logic      [7:0]              std_pmos_on,
    output logic      [7:0]              std_nmos_on,
    output logic      [7:0]              std_pullup_on,
    // On-chip peripherals
    input  wire pbip_pkg::pbip_per_s     per_req,
    output logic      [7:0]              per_sel,
    output logic      [7:0]              per_in,
    output logic      [1:0]              sclk_ext,
    // Power mode
    input  wire logic                    low_power
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (SCLK_A_BIT < 0 || SCLK_A_BIT > 7 || SCLK_B_BIT < 0 ||
        SCLK_B_BIT > 7 || SCLK_A_BIT == SCLK_B_BIT)
    begin : g_bad_sclk
        $error("pbip_top: serial clock pin positions out of range");
    end

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] pick(input logic [7:0] sel,
                                        input logic [7:0] a,
                                        input logic [7:0] b);
        pick = (sel & a) | (~sel & b);
    endfunction

    function automatic logic [15:0] widx(input logic [`PBIP_ADDR_W-1:0] a);
        widx = a[`PBIP_ADDR_W-1:2];
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]  an_sel_r;
    logic [7:0]  data_r;
    logic [7:0]  dir_r;
    logic [7:0]  func_r;
    logic [1:0]  sclk_r;
    logic [7:0]  p0_sync;
    logic [7:0]  std_sync;
    logic [7:0]  in_only;
    logic [7:0]  p0_level;
    logic [7:0]  std_level;
    pbip_drv_s   drv;
    pbip_wr_e    wr_st_r;
    pbip_rd_e    rd_st_r;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] wr_idx;
    logic [15:0] rd_idx;
    logic [7:0]  wr_byte;
    logic        wr_lane;
    logic        wr_hit;
    logic [31:0] rdata_nxt;
    logic        rd_hit;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pbip_sync #(
        .W       (8)
    ) u_p0_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (p0_pin_i),
        .q       (p0_sync)
    );

    pbip_sync #(
        .W       (8)
    ) u_std_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (std_pin_i),
        .q       (std_sync)
    );

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data are taken together so no skid storage is needed
    always_comb
    begin
        wr_fire       = (wr_st_r == PBIP_WR_IDLE) &&
                        s_axi_awvalid && s_axi_wvalid;
        s_axi_awready = wr_fire;
        s_axi_wready  = wr_fire;
        wr_idx        = widx(s_axi_awaddr);
        wr_byte       = s_axi_wdata[7:0];
        wr_lane       = s_axi_wstrb[0];
        wr_hit        = (wr_idx == `PBIP_IDX_P0_LEVEL) ||
                        (wr_idx == `PBIP_IDX_P0_ASEL) ||
                        (wr_idx == `PBIP_IDX_DATA) ||
                        (wr_idx == `PBIP_IDX_DIR) ||
                        (wr_idx == `PBIP_IDX_FUNC) ||
                        (wr_idx == `PBIP_IDX_SCLK);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_st_r      <= PBIP_WR_IDLE;
            s_axi_bresp  <= `PBIP_RESP_OKAY;
        end
        else
        begin
            unique case (wr_st_r)
                PBIP_WR_IDLE:
                begin
                    if (wr_fire)
                    begin
                        wr_st_r     <= PBIP_WR_RESP;
                        s_axi_bresp <= wr_hit ? `PBIP_RESP_OKAY
                                              : `PBIP_RESP_SLVERR;
                    end
                end
                PBIP_WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_st_r <= PBIP_WR_IDLE;
                    end
                end
            endcase
        end
    end

    assign s_axi_bvalid = (wr_st_r == PBIP_WR_RESP);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            an_sel_r <= `PBIP_P0_ASEL_RST;
        end
        else if (wr_fire && wr_lane && wr_idx == `PBIP_IDX_P0_ASEL)
        begin
            an_sel_r <= wr_byte;
        end
    end

    // Input-level index has no storage, so a write there is dropped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_r <= `PBIP_DATA_RST;
            dir_r  <= `PBIP_DIR_RST;
            func_r <= `PBIP_FUNC_RST;
            sclk_r <= `PBIP_SCLK_RST;
        end
        else if (wr_fire && wr_lane)
        begin
            if (wr_idx == `PBIP_IDX_DATA)
            begin
                data_r <= wr_byte;
            end
            if (wr_idx == `PBIP_IDX_DIR)
            begin
                dir_r <= wr_byte;
            end
            if (wr_idx == `PBIP_IDX_FUNC)
            begin
                func_r <= wr_byte;
            end
            if (wr_idx == `PBIP_IDX_SCLK)
            begin
                sclk_r <= wr_byte[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Port 0
    // ----------------------------------------------------------------
    // No output exists for these pins at all
    assign p0_adc_route = an_sel_r;
    assign p0_gen_in    = p0_sync & ~an_sel_r;
    assign p0_level     = pick(an_sel_r, 8'hFF, p0_sync);

    // ----------------------------------------------------------------
    // Standard port
    // ----------------------------------------------------------------
    always_comb
    begin
        in_only = 8'h00;
        in_only[SCLK_A_BIT] = sclk_r[`PBIP_SCLK_A_EXT];
        in_only[SCLK_B_BIT] = sclk_r[`PBIP_SCLK_B_EXT];
    end

    pbip_drive #(
        .PULLUP_BUILT (PULLUP_BUILT)
    ) u_drive (
        .aclk    (aclk),
        .aresetn (aresetn),
        .data    (data_r),
        .dir     (dir_r),
        .func    (func_r),
        .in_only (in_only),
        .per     (per_req),
        .drv     (drv)
    );

    assign std_pin_o     = drv.pin_o;
    assign std_pin_oe    = drv.pin_oe;
    assign std_pmos_on   = drv.pmos_on;
    assign std_nmos_on   = drv.nmos_on;
    assign std_pullup_on = drv.pullup_on;
    assign per_sel       = func_r;
    assign sclk_ext      = sclk_r;

    // Peripheral pins read the pin level; plain outputs read the latch
    assign std_level = pick(dir_r & ~func_r, data_r, std_sync);

    // Low-power mode does not gate peripheral inputs; floating pins
    // will draw extra current, which software must avoid.
    assign per_in = std_sync;

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_fire   = (rd_st_r == PBIP_RD_IDLE) && s_axi_arvalid;
        rd_idx    = widx(s_axi_araddr);
        rdata_nxt = 32'h0000_0000;
        rd_hit    = 1'b1;
        unique case (rd_idx)
            `PBIP_IDX_P0_LEVEL: rdata_nxt[7:0] = p0_level;
            `PBIP_IDX_P0_ASEL:  rdata_nxt[7:0] = 8'h00;
            `PBIP_IDX_DATA:     rdata_nxt[7:0] = std_level;
            `PBIP_IDX_DIR:      rdata_nxt[7:0] = dir_r;
            `PBIP_IDX_FUNC:     rdata_nxt[7:0] = func_r;
            `PBIP_IDX_SCLK:     rdata_nxt[1:0] = sclk_r;
            default:            rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = (rd_st_r == PBIP_RD_IDLE);
    assign s_axi_rvalid  = (rd_st_r == PBIP_RD_DATA);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_st_r     <= PBIP_RD_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PBIP_RESP_OKAY;
        end
        else
        begin
            unique case (rd_st_r)
                PBIP_RD_IDLE:
                begin
                    if (rd_fire)
                    begin
                        rd_st_r     <= PBIP_RD_DATA;
                        s_axi_rdata <= rdata_nxt;
                        s_axi_rresp <= rd_hit ? `PBIP_RESP_OKAY
                                              : `PBIP_RESP_SLVERR;
                    end
                end
                PBIP_RD_DATA:
                begin
                    if (s_axi_rready)
                    begin
                        rd_st_r <= PBIP_RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking

    default disable iff (!aresetn);

    a_reset_clears_regs: assert property (
        disable iff (1'b0)
        !aresetn |=> (data_r == 8'h00 && dir_r == 8'h00 &&
                      func_r == 8'h00 && sclk_r == 2'h0))
        else $error("port registers not cleared by reset");

    a_reset_asel_zero: assert property (
        disable iff (1'b0)
        !aresetn ##1 aresetn |-> p0_adc_route == 8'h00)
        else $error("analog select not zero after reset");

    a_lowpow_inputs_live: assert property (
        low_power && $past(aresetn) && $past(aresetn, 2) &&
        std_pin_i == $past(std_pin_i) && std_pin_i == $past(std_pin_i, 2)
        |-> per_in == std_pin_i)
        else $error("peripheral input gated in low power");

    a_sclk_not_driven: assert property (
        sclk_r[`PBIP_SCLK_A_EXT] && $past(sclk_r[`PBIP_SCLK_A_EXT])
        |-> !std_pin_oe[SCLK_A_BIT] && !std_pmos_on[SCLK_A_BIT] &&
            !std_nmos_on[SCLK_A_BIT])
        else $error("serial clock pin driven in external mode");

    a_drive_off_dir0: assert property (
        ##1 ((std_pmos_on | std_nmos_on) &
             ~$past(dir_r | func_r)) == 8'h00)
        else $error("driver on while pin is an input");

    a_drive_polarity: assert property (
        $past(dir_r & ~func_r & ~in_only) == 8'hFF
        |-> std_pmos_on == $past(data_r) &&
            std_nmos_on == ~$past(data_r))
        else $error("driver polarity does not follow data");

    a_pullup_always: assert property (
        ##1 std_pullup_on == (PULLUP_BUILT ? 8'hFF : 8'h00))
        else $error("pull-up state depends on port settings");

    a_level_read: assert property (
        rd_fire && rd_idx == `PBIP_IDX_P0_LEVEL
        |=> s_axi_rvalid &&
            s_axi_rdata[7:0] == ($past(p0_sync) | $past(an_sel_r)))
        else $error("input level read value wrong");

    a_level_write_drop: assert property (
        wr_fire && wr_idx == `PBIP_IDX_P0_LEVEL |=> $stable(an_sel_r))
        else $error("write to input level changed state");

    a_asel_next_cycle: assert property (
        wr_fire && wr_lane && wr_idx == `PBIP_IDX_P0_ASEL
        |=> p0_adc_route == $past(wr_byte))
        else $error("analog select write not applied next cycle");

    a_std_read_value: assert property (
        rd_fire && rd_idx == `PBIP_IDX_DATA
        |=> s_axi_rdata[7:0] == $past(pick(dir_r & ~func_r, data_r,
                                           std_sync)))
        else $error("standard port read value wrong");

endmodule

//--- verification/pbip_pins.sv
// Model of the pads and the outside world around the port block
module pbip_pins
(
    // Clock
    input  wire logic       aclk,
    // Pad drive from the block
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    // Outside drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] p0_level,
    // Levels seen by the block
    output logic      [7:0] std_level,
    output logic      [7:0] p0_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] float_r = 8'h5A;

    // A floating pad keeps no stale value: it toggles every cycle
    always_ff @(posedge aclk)
        float_r <= ~float_r;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                std_level[i] = pin_o[i];
            else if (ext_en[i])
                std_level[i] = ext_val[i];
            else if (pullup_on[i])
                std_level[i] = 1'b1;
            else
                std_level[i] = float_r[i];
        end
    end

    // Port 0 has no driver inside the block, only the outside sets it
    assign p0_pin = p0_level;
endmodule

//--- verification/tb.sv
// Self-checking testbench of the port block
`include "pbip_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pbip_pkg::*;

    localparam int SA = 1;
    localparam int SB = 4;
    localparam logic [1:0] OK = `PBIP_RESP_OKAY;
    localparam logic [1:0] ERR = `PBIP_RESP_SLVERR;

    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, low_power;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sclk_ext;
    logic [7:0]  p0_pin_i, p0_adc_route, p0_gen_in, std_pin_i, std_pin_o;
    logic [7:0]  std_pin_oe, std_pmos_on, std_nmos_on, std_pullup_on;
    logic [7:0]  per_sel, per_in, ext_en, ext_val, p0_lvl, a, d, r, lv;
    pbip_per_s   per_req;
    logic [1:0]  exp_b[$];
    logic [34:0] exp_r[$];
    logic [34:0] er;
    int n_errors = 0;
    int comparisons = 0;

    pbip_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .p0_pin_i(p0_pin_i),
        .p0_adc_route(p0_adc_route), .p0_gen_in(p0_gen_in),
        .std_pin_i(std_pin_i), .std_pin_o(std_pin_o),
        .std_pin_oe(std_pin_oe), .std_pmos_on(std_pmos_on),
        .std_nmos_on(std_nmos_on), .std_pullup_on(std_pullup_on),
        .per_req(per_req), .per_sel(per_sel), .per_in(per_in),
        .sclk_ext(sclk_ext), .low_power(low_power));

    pbip_pins u_pins (.aclk(aclk), .pin_o(std_pin_o), .pin_oe(std_pin_oe),
        .pullup_on(std_pullup_on), .ext_en(ext_en), .ext_val(ext_val),
        .p0_level(p0_lvl), .std_level(std_pin_i), .p0_pin(p0_pin_i));

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A wait that runs out of its bound ends the run
    task automatic tmo(input int n);
        if (n >= 100)
        begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic axi_wr(input logic [15:0] idx, input logic [7:0] v,
                          input logic [1:0] e);
        int n;
        exp_b.push_back(e);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!(s_axi_awready && s_axi_wready) && n < 100);
        tmo(n);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_bvalid && n < 100);
        tmo(n);
    endtask

    // Flag bit 34 says whether the read data are compared
    task automatic axi_rd(input logic [15:0] idx, input logic [34:0] e);
        int n;
        exp_r.push_back(e);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 100);
        tmo(n);
        s_axi_arvalid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < 100);
        tmo(n);
    endtask

    // Answers are matched against the oldest note of their channel
    always @(posedge aclk)
    begin
        if (aresetn && s_axi_bvalid && s_axi_bready)
            chk("bresp", exp_b.pop_front(), s_axi_bresp);
        if (aresetn && s_axi_rvalid && s_axi_rready)
        begin
            er = exp_r.pop_front();
            chk("rresp", er[33:32], s_axi_rresp);
            if (er[34])
                chk("rdata", er[31:0], s_axi_rdata);
        end
    end

    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask

    task automatic chk_cleared();
        chk("route", 8'h00, p0_adc_route);
        chk("per_sel", 8'h00, per_sel);
        chk("sclk_ext", 2'h0, sclk_ext);
        chk("oe", 8'h00, std_pin_oe);
        chk("drivers", 16'h0000, {std_pmos_on, std_nmos_on});
    endtask

    initial
    begin
        seed = 32'h000011D4;
        // Answers are always accepted, so back-to-back calls never
        // lower and raise a ready in the same time step
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
        {s_axi_arvalid, s_axi_rready, low_power} = 3'h2;
        s_axi_awaddr = 18'h00000;
        s_axi_araddr = 18'h00000;
        s_axi_wdata = 32'h00000000;
        per_req = {rnd(), rnd()};
        ext_en = 8'hFF;
        ext_val = rnd();
        p0_lvl = rnd();
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk_cleared();
        chk("pullup", 8'hFF, std_pullup_on);
        axi_rd(`PBIP_IDX_P0_LEVEL, {1'b1, OK, 24'h0, p0_lvl});
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd();
            axi_wr(`PBIP_IDX_P0_ASEL, a, OK);
            chk("route", a, p0_adc_route);
            p0_lvl <= rnd();
            settle();
            chk("gen_in", p0_lvl & ~a, p0_gen_in);
            axi_rd(`PBIP_IDX_P0_LEVEL, {1'b1, OK, 24'h0, p0_lvl | a});
            axi_wr(`PBIP_IDX_P0_LEVEL, rnd(), OK);
            axi_rd(`PBIP_IDX_P0_ASEL, {1'b1, OK, 32'h0});
            chk("route", a, p0_adc_route);
        end
        for (int i = 0; i < 4; i++)
        begin
            d = rnd();
            r = (i == 0) ? 8'hFF : rnd();
            axi_wr(`PBIP_IDX_DATA, d, OK);
            axi_wr(`PBIP_IDX_DIR, r, OK);
            ext_val <= rnd();
            ext_en <= (i == 3) ? 8'h00 : 8'hFF;
            low_power <= i[0];
            settle();
            lv = (r & d) | (~r & (ext_en[0] ? ext_val : 8'hFF));
            chk("pmos", r & d, std_pmos_on);
            chk("nmos", r & ~d, std_nmos_on);
            chk("oe", r, std_pin_oe);
            chk("pin_o", d, std_pin_o);
            chk("pullup", 8'hFF, std_pullup_on);
            chk("per_in", lv, per_in);
            axi_rd(`PBIP_IDX_DATA, {1'b1, OK, 24'h0, lv});
        end
        axi_wr(`PBIP_IDX_DIR, 8'hFF, OK);
        axi_wr(`PBIP_IDX_SCLK, 8'h03, OK);
        settle();
        chk("sclk_ext", 2'h3, sclk_ext);
        chk("oe_sclk", 2'h0, {std_pin_oe[SA], std_pin_oe[SB]});
        chk("drv_sclk", 4'h0, {std_pmos_on[SA], std_pmos_on[SB],
            std_nmos_on[SA], std_nmos_on[SB]});
        a = rnd();
        axi_wr(`PBIP_IDX_FUNC, a, OK);
        chk("per_sel", a, per_sel);
        settle();
        chk("oe_per", 8'(((a & per_req.oe) | ~a) &
            ~((8'h01 << SA) | (8'h01 << SB))), std_pin_oe);
        chk("pin_o_per", 8'((a & per_req.out) | (~a & d)),
            std_pin_o);
        axi_wr(16'h0100, rnd(), ERR);
        axi_rd(16'h0100, {1'b0, ERR, 32'h0});
        axi_wr(`PBIP_IDX_P0_ASEL, 8'hFF, OK);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk_cleared();
        repeat (2) @(posedge aclk);
        wrap_up();
    end
endmodule
